/* File: verilog/bmsf_mode_sense.v */
// mode-sense classifier, debounce, driver and terminator mode control
//
// Overview of operation
// R1 - tell single-ended, low-voltage and high-voltage differential bus modes apart
// R2 - classify by comparator band: low is SE, middle is LOW_VOLTAGE_DIFF_MODE, high is HIGH_VOLTAGE_DIFF_MODE
// R3 - the two gaps between bands give no valid mode
// R4 - keep every bus driver high impedance for 100 ms after power-on
// R5 - then also require the sensed mode stable another 100 ms
// R6 - change the operating mode only after 100 ms of continuous new mode
// R7 - terminator mode follows the classified bus mode, LOW_VOLTAGE_DIFF_MODE or MULTIMODE_SINGLE_ENDED
// R8 - keep sourcing the LOW_VOLTAGE_DIFF_MODE level onto the sense line while sensing it
// R9 - terminator ground driver on while single-ended mode is indicated
// R10 - in HIGH_VOLTAGE_DIFF_MODE mode all bus signals except the sense line go high impedance
// R11 - transceiver ground drivers enabled while powered and sensing SE; the code enables them only once SE is the accepted mode
// R12 - 100 ms counter restarts on class change; indeterminate samples ignored
// R13 - accepted mode cleared at reset; drivers off until first mode accepted
//
// Local design decisions: the register offsets and register access over Wishbone.
`include "bmsf_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module bmsf_mode_sense #(
   parameter STABLE_CYC = `BMSF_STABLE_CYC
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        sense_above_lo_i,
   input  wire        sense_at_lvd_lo_i,
   input  wire        sense_above_lvd_hi_i,
   input  wire        sense_at_hvd_lo_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         drivers_en_o,
   output reg         single_ended_mode_o,
   output reg         low_voltage_diff_mode_o,
   output reg         high_voltage_diff_mode_o,
   output reg         term_lvd_o,
   output reg         term_multimode_single_ended_o,
   output reg         term_sense_source_o,
   output reg         ground_drv_en_o,
   output reg         irq_o
);
   localparam ST_POWER  = 2'h0;
   localparam ST_SETTLE = 2'h1;
   localparam ST_RUN    = 2'h2;

   // ****************************************
   // band classification
   // ****************************************
   // comparator outputs: above 0,5V, at/above 0,7V, above 1,9V, at/above 2,4V
   function [1:0] bmsf_classify;
      input [3:0] c;
      begin
         case (c)
            4'h0:    bmsf_classify = `BMSF_MODE_SE;     // see R2
            4'h3:    bmsf_classify = `BMSF_MODE_LVD;    // see R2
            4'hF:    bmsf_classify = `BMSF_MODE_HVD;    // see R2
            default: bmsf_classify = `BMSF_MODE_NONE;   // see R3
         endcase
      end
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   reg  [3:0]  sync1_r;
   reg  [3:0]  sync2_r;
   reg  [3:0]  sync3_r;
   reg  [3:0]  cmp_r;
   wire [3:0]  cmp_raw;
   assign cmp_raw = {sense_at_hvd_lo_i, sense_above_lvd_hi_i, sense_at_lvd_lo_i, sense_above_lo_i};

   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         sync3_r <= 4'h0;
         cmp_r   <= 4'h0;
      end else begin
         sync1_r <= cmp_raw;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         // a bit counts only once two stages agree, filtering single-cycle races
         cmp_r   <= (sync2_r & sync3_r) | (cmp_r & (sync2_r | sync3_r));
      end
   end

   wire [1:0] sample_class;
   assign sample_class = bmsf_classify(cmp_r);    // see R1

   // ****************************************
   // debounce and mode acceptance
   // ****************************************
   reg  [1:0]  state_r;
   reg  [31:0] cnt_r;
   reg  [1:0]  cand_r;
   reg  [1:0]  mode_r;
   reg         accept_ev_r;
   reg         change_ev_r;
   reg         indet_ev_r;
   wire        cnt_done;
   assign cnt_done = (cnt_r >= STABLE_CYC - 1);

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r     <= ST_POWER;
         cnt_r       <= 32'h0;
         cand_r      <= `BMSF_MODE_NONE;
         mode_r      <= `BMSF_MODE_NONE;    // see R13
         accept_ev_r <= 1'b0;
         change_ev_r <= 1'b0;
         indet_ev_r  <= 1'b0;
      end else begin
         accept_ev_r <= 1'b0;
         change_ev_r <= 1'b0;
         indet_ev_r  <= (sample_class == `BMSF_MODE_NONE) && (cand_r != `BMSF_MODE_NONE);
         case (state_r)
            ST_POWER: begin
               // logic operational interval, mode is not looked at yet
               if (cnt_done) begin    // see R4
                  cnt_r   <= 32'h0;
                  state_r <= ST_SETTLE;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            ST_SETTLE, ST_RUN: begin
               // indeterminate samples hold the count and the candidate
               if (sample_class != `BMSF_MODE_NONE) begin    // see R12
                  if (sample_class != cand_r) begin
                     cand_r <= sample_class;    // see R12
                     cnt_r  <= 32'h0;
                  end else if (sample_class == mode_r) begin
                     cnt_r <= 32'h0;
                  end else if (cnt_done) begin
                     mode_r  <= cand_r;    // see R5
                     cnt_r   <= 32'h0;
                     state_r <= ST_RUN;
                     accept_ev_r <= (state_r == ST_SETTLE);
                     change_ev_r <= (state_r == ST_RUN);    // see R6
                  end else begin
                     cnt_r <= cnt_r + 32'h1;
                  end
               end
            end
            default: begin
               state_r <= ST_POWER;
               cnt_r   <= 32'h0;
            end
         endcase
      end
   end

   // ****************************************
   // wishbone registers
   // ****************************************
   reg  [7:0]  ctrl_r;
   reg  [2:0]  irq_stat_r;
   reg  [2:0]  irq_mask_r;
   wire        wb_req;
   wire        wr_stat;
   wire [2:0]  ev;
   assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_stat = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `BMSF_OFF_IRQ_STAT);
   assign ev      = {indet_ev_r, change_ev_r, accept_ev_r};

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h0;
         ctrl_r     <= `BMSF_CTRL_RST;
         irq_stat_r <= 3'h0;
         irq_mask_r <= 3'h0;
      end else begin
         wb_ack_o <= wb_req;
         // set wins over write-one-to-clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~(wr_stat ? wb_dat_i[2:0] : 3'h0)) | ev;
         if (wb_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `BMSF_OFF_CTRL)
               ctrl_r <= wb_dat_i[7:0];
            if (wb_adr_i == `BMSF_OFF_IRQ_MASK)
               irq_mask_r <= wb_dat_i[2:0];
         end
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `BMSF_OFF_CTRL:     wb_dat_o <= {24'h0, ctrl_r};
               `BMSF_OFF_STATUS:   wb_dat_o <= {24'h0, state_r, 2'h0, cand_r, mode_r};
               `BMSF_OFF_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_r};
               `BMSF_OFF_IRQ_MASK: wb_dat_o <= {29'h0, irq_mask_r};
               default:            wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // ****************************************
   // driver, terminator and ground control
   // ****************************************
   wire term_on;
   assign term_on = ctrl_r[`BMSF_CTRL_TERM_EN];

   always @(posedge clk_i) begin
      if (rst_i) begin
         drivers_en_o                  <= 1'b0;
         single_ended_mode_o           <= 1'b0;
         low_voltage_diff_mode_o       <= 1'b0;
         high_voltage_diff_mode_o      <= 1'b0;
         term_lvd_o                    <= 1'b0;
         term_multimode_single_ended_o <= 1'b0;
         term_sense_source_o           <= 1'b0;
         ground_drv_en_o               <= 1'b0;
         irq_o                         <= 1'b0;
      end else begin
         // no mode accepted means still in power-on or settle interval
         drivers_en_o <= (state_r == ST_RUN) &&
                         ((mode_r == `BMSF_MODE_SE) || (mode_r == `BMSF_MODE_LVD));    // see R10 see R13
         single_ended_mode_o      <= (mode_r == `BMSF_MODE_SE);
         low_voltage_diff_mode_o  <= (mode_r == `BMSF_MODE_LVD);
         high_voltage_diff_mode_o <= (mode_r == `BMSF_MODE_HVD);
         term_lvd_o                    <= term_on && (mode_r == `BMSF_MODE_LVD);    // see R7
         term_multimode_single_ended_o <= term_on && (mode_r == `BMSF_MODE_SE);     // see R7
         // source stays on regardless of the sensed mode
         term_sense_source_o <= term_on;    // see R8
         // follows the accepted mode, so a short dip to SE does not toggle grounds
         ground_drv_en_o <= (mode_r == `BMSF_MODE_SE);    // see R9 see R11
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end
endmodule
`default_nettype wire

/* File: shared/bmsf_defs.vh */
// constants for the bus mode sense filter
`ifndef BMSF_DEFS_VH
`define BMSF_DEFS_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define BMSF_OFF_CTRL       8'h00
`define BMSF_OFF_STATUS     8'h04
`define BMSF_OFF_IRQ_STAT   8'h08
`define BMSF_OFF_IRQ_MASK   8'h0C
// ****************************************
// mode encodings
// ****************************************
`define BMSF_MODE_NONE      2'h0
`define BMSF_MODE_SE        2'h1
`define BMSF_MODE_LVD       2'h2
`define BMSF_MODE_HVD       2'h3
// ****************************************
// control fields and reset values
// ****************************************
`define BMSF_CTRL_TERM_EN   0
`define BMSF_CTRL_RST       8'h01
// ****************************************
// irq bits
// ****************************************
`define BMSF_IRQ_ACCEPT     0
`define BMSF_IRQ_CHANGE     1
`define BMSF_IRQ_INDET      2
// ****************************************
// timing
// ****************************************
`define BMSF_CLK_HZ         20000000
`define BMSF_STABLE_MS      100
`define BMSF_STABLE_CYC     ((`BMSF_CLK_HZ / 1000) * `BMSF_STABLE_MS)
`endif

/* File: bench/bmsf_sense_model.sv */
// window comparator model of the shared mode sense line
`timescale 1ns/100ps
`default_nettype none
module bmsf_sense_model (
   input  wire logic [12:0] mv_i,
   output logic             above_lo_o,
   output logic             at_lvd_lo_o,
   output logic             above_lvd_hi_o,
   output logic             at_hvd_lo_o
);
   // thresholds in mV; each gap between bands yields a mixed code
   assign above_lo_o     = mv_i > 13'h1F4;
   assign at_lvd_lo_o    = mv_i >= 13'h2BC;
   assign above_lvd_hi_o = mv_i > 13'h76C;
   assign at_hvd_lo_o    = mv_i >= 13'h960;
endmodule
`default_nettype wire

/* File: bench/bmsf_mode_sense_properties.sv */
// port assertions for the mode sense filter
`timescale 1ns/100ps
`default_nettype none
module bmsf_mode_sense_properties #(parameter STABLE_CYC = 20) (
   input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, drivers_en_o,
   input wire logic sense_above_lo_i, sense_at_lvd_lo_i, sense_above_lvd_hi_i, sense_at_hvd_lo_i,
   input wire logic single_ended_mode_o, low_voltage_diff_mode_o, high_voltage_diff_mode_o,
   input wire logic term_lvd_o, term_multimode_single_ended_o, term_sense_source_o, ground_drv_en_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire [3:0] raw = {sense_at_hvd_lo_i, sense_above_lvd_hi_i, sense_at_lvd_lo_i, sense_above_lo_i};
   wire [2:0] cls = raw == 4'h0 ? 3'h1 : raw == 4'h3 ? 3'h2 : raw == 4'hF ? 3'h4 : 3'h0;
   wire [2:0] mode = {high_voltage_diff_mode_o, low_voltage_diff_mode_o, single_ended_mode_o};
   logic [2:0] last_r;
   integer     run_r;
   integer     up_r;
   // raw run length runs ahead of the synchronised one, so the bound is safe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         up_r <= 0;
         run_r <= 0;
         last_r <= 3'h0;
      end else begin
         up_r <= up_r + 1;
         if (cls != 3'h0 && cls != last_r) begin
            run_r <= 0;
            last_r <= cls;
         end else if (cls != 3'h0) begin
            run_r <= run_r + 1;
         end
      end
   end
   AST_ONE_MODE: assert property ($onehot0(mode))
      else $error("more than one mode");
   AST_MODE_CLASS: assert property ($changed(mode) |-> mode == last_r && run_r >= STABLE_CYC)
      else $error("mode changed without a stable class");
   AST_PWR_HOLD: assert property (drivers_en_o || mode != 3'h0 |-> up_r >= 2 * STABLE_CYC)
      else $error("mode or drivers too early");
   AST_DRV_MODE: assert property (drivers_en_o |-> single_ended_mode_o || low_voltage_diff_mode_o)
      else $error("drivers on without se or lvd");
   AST_DRV_ON: assert property ($rose(single_ended_mode_o) || $rose(low_voltage_diff_mode_o) |-> ##[0:1] drivers_en_o)
      else $error("drivers not enabled");
   AST_GND_SE: assert property (ground_drv_en_o == single_ended_mode_o)
      else $error("ground driver differs from se mode");
   AST_TERM_LVD: assert property (term_lvd_o |-> low_voltage_diff_mode_o && term_sense_source_o)
      else $error("lvd termination wrong");
   AST_TERM_MSE: assert property (term_multimode_single_ended_o |-> single_ended_mode_o)
      else $error("se termination wrong");
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
endmodule
bind bmsf_mode_sense bmsf_mode_sense_properties #(.STABLE_CYC(STABLE_CYC)) u_prop (.*);
`default_nettype wire

/* File: bench/bmsf_mode_sense_tb.sv */
// self-checking bench for the mode sense filter
`timescale 1ns/100ps
`default_nettype none
module bmsf_mode_sense_tb;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, q;
   logic [12:0] mv = 13'h514, cur;
   wire sense_above_lo_i, sense_at_lvd_lo_i, sense_above_lvd_hi_i, sense_at_hvd_lo_i, wb_ack_o, irq_o;
   wire drivers_en_o, single_ended_mode_o, low_voltage_diff_mode_o, high_voltage_diff_mode_o;
   wire term_lvd_o, term_multimode_single_ended_o, term_sense_source_o, ground_drv_en_o;
   wire [31:0] wb_dat_o;
   wire [2:0] mode = {high_voltage_diff_mode_o, low_voltage_diff_mode_o, single_ended_mode_o};
   integer fails = 0, checked = 0, c, p;
   logic [2:0] m;
   bmsf_mode_sense #(.STABLE_CYC(20)) uut (.*);
   bmsf_sense_model pm (.mv_i(mv), .above_lo_o(sense_above_lo_i), .at_lvd_lo_o(sense_at_lvd_lo_i),
      .above_lvd_hi_o(sense_above_lvd_hi_i), .at_hvd_lo_o(sense_at_hvd_lo_i));
   always #25 clk_i = ~clk_i;
   task print_verdict;
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      integer n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hF};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (n >= 50) fails++;
      if (n >= 50) print_verdict;
   endtask
   task hold(input logic [12:0] v, input integer n);
      mv <= v;
      repeat (n) @(posedge clk_i);
   endtask
   task wait_mode(input logic [2:0] e);
      integer n;
      n = 0;
      while (mode !== e && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 300) fails++;
      if (n >= 300) print_verdict;
      @(posedge clk_i);
   endtask
   function logic [2:0] exp_mode(input logic [12:0] v);
      return v <= 500 ? 3'h1 : (v >= 700 && v <= 1900) ? 3'h2 : v >= 2400 ? 3'h4 : 3'h0;
   endfunction
   function logic [12:0] rnd_mv(input integer k);
      return k == 0 ? $urandom % 501 : k == 1 ? 700 + $urandom % 1201 : 2400 + $urandom % 3101;
   endfunction
   initial begin
      repeat (4000) @(posedge clk_i);
      fails++;
      print_verdict;
   end
   initial begin
      void'($urandom(32'h94c6));
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      repeat (40) begin
         @(posedge clk_i);
         chk(drivers_en_o, 0);
      end
      wait_mode(3'h2);
      chk({drivers_en_o, term_lvd_o, term_sense_source_o, ground_drv_en_o}, 4'hE);
      wb(0, 8'h00, 0);
      chk(q, 32'h01);
      wb(0, 8'h10, 0);
      chk(q, 32'h0);
      wb(0, 8'h08, 0);
      chk(q, 32'h01);
      wb(0, 8'h04, 0);
      chk(q, 32'h8A);
      wb(1, 8'h0C, 32'h03);
      @(posedge clk_i);
      chk(irq_o, 1);
      cur = mv;
      foreach (m[k]) begin
         c = k == 0 ? 0 : k == 1 ? 2 : 1;
         p = rnd_mv(c);
         // short burst of the new class, a gap, then back: mode must hold
         hold(p, 10);
         hold(13'h258, 5);
         hold(cur, 10);
         chk(mode, exp_mode(cur));
         hold(p, 8);
         hold(13'h898, 6);
         mv <= p;
         wait_mode(exp_mode(p));
         m = exp_mode(p);
         chk({ground_drv_en_o, drivers_en_o, term_multimode_single_ended_o}, {m[0], ~m[2], m[0]});
         chk(irq_o, 1);
         wb(1, 8'h08, 32'h07);
         @(posedge clk_i);
         chk(irq_o, 0);
         cur = p;
      end
      c = 1;
      repeat (20) begin
         c = (c + 1 + $urandom % 2) % 3;
         hold(rnd_mv(c), 4 + $urandom % 9);
      end
      hold(cur, 30);
      chk(mode, exp_mode(cur));
      wb(1, 8'h00, 32'h0);
      @(posedge clk_i);
      chk({term_lvd_o, term_sense_source_o, term_multimode_single_ended_o}, 0);
      print_verdict;
   end
endmodule
`default_nettype wire
